/* hdl/rmc_mailbox.sv */
// Purpose: One 32-bit mailbox bypass register with its mail flag
// Assumes: Write and read requests already decoded by the caller
// Notes: Flag high means empty; a write is taken only then
`include "rmc_consts.svh"

module rmc_mailbox (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic wrReq,
  input wire logic rdReq,
  input wire logic [`RMC_DATA_W-1:0] wrData,
  output logic [`RMC_DATA_W-1:0] mailWord,
  output logic mailFlag
);

  logic wrTaken;

  // Writes are dropped while the flag is low
  assign wrTaken = wrReq && mailFlag; // R17

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mailWord <= `RMC_MAIL_RESET;
    end else if (wrTaken) begin
      mailWord <= wrData; // R21
    end
  end

  // New mail wins over a read in the same edge
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mailFlag <= 1'b1;
    end else if (wrTaken) begin
      mailFlag <= 1'b0; // R17
    end else if (rdReq) begin
      mailFlag <= 1'b1; // R19 R20
    end
  end

endmodule

/* hdl/rmc_queue_mem.sv */
// Purpose: 512 x 32 storage of the A-to-B queue
// Assumes: One write port, one combinational read port
// Notes: Read is asynchronous so a shift completes in one edge
`include "rmc_consts.svh"

module rmc_queue_mem (
  input wire logic mclk,
  input wire logic wrEn,
  input wire logic [`RMC_ADDR_W-1:0] wrAddr,
  input wire logic [`RMC_DATA_W-1:0] wrData,
  input wire logic [`RMC_ADDR_W-1:0] rdAddr,
  output logic [`RMC_DATA_W-1:0] rdData
);

  logic [`RMC_DATA_W-1:0] store [0:(1<<`RMC_ADDR_W)-1];

  always_ff @(posedge mclk) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
  end

  assign rdData = store[rdAddr];

endmodule

/* hdl/rmc_retransmit_mailbox.sv */
// Purpose: A-to-B queue with synchronous retransmit, two mailboxes
// Assumes: Both ports run on mclk; pin inputs synchronous to it
// Notes: Offsets are static inputs; reset of the queue is arst_n
//
// What this block does
// (R1) Request with output ready enters retransmit
// (R2) Request low on an edge leaves retransmit
// (R3) Controller keeps retransmit vectors three words minimum
// (R4) Two reads past mark, then replay allowed
// (R5) Controller keeps replay low on exit edge
// (R6) Current pointer advances, drives output flags
// (R7) Shadow pointer holds mark, drives input flags
// (R8) Writes continue; flags fall by shadow fill
// (R9) Replay loads current pointer; ready immediate
// (R10) Almost-empty rises within two edges after replay
// (R11) Exit switches port A flags to current
// (R12) Port A flag rise waits two edges
// (R13) Only retransmit pins control retransmit
// (R14) Each direction has a 32-bit mailbox
// (R15) Port A mailbox write on select
// (R16) Port B mailbox write on select
// (R17) Write lowers mail flag; writes ignored then
// (R18) Port data from queue or mailbox select
// (R19) Port B mailbox read raises B flag
// (R20) Port A mailbox read raises A flag
// (R21) Mailbox read keeps contents intact
// (R22) Controller uses documented select levels for queue
// (R23) Output not ready keeps word, ignores reads
`include "rmc_consts.svh"

module rmc_retransmit_mailbox (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic portAChipSelect_n,
  input wire logic portADirection,
  input wire logic portAEnable,
  input wire logic portAMailboxSelect,
  input wire logic [`RMC_DATA_W-1:0] portABusIn,
  output logic [`RMC_DATA_W-1:0] portABusOut,
  output logic portABusOe,
  input wire logic [`RMC_DATA_W-1:0] baQueueWord,
  input wire logic portBChipSelect_n,
  input wire logic portBDirection,
  input wire logic portBEnable,
  input wire logic portBMailboxSelect,
  input wire logic [`RMC_DATA_W-1:0] portBBusIn,
  output logic [`RMC_DATA_W-1:0] portBBusOut,
  output logic portBBusOe,
  input wire logic retransmitModeRequest,
  input wire logic readFromMark,
  input wire logic [`RMC_OFS_W-1:0] fifo1FullOffset,
  input wire logic [`RMC_OFS_W-1:0] fifo1EmptyOffset,
  output logic portAInputReady,
  output logic portAAlmostFull,
  output logic portBOutputReady,
  output logic portBAlmostEmpty,
  output logic retransmitActive,
  output logic mailToBFlag,
  output logic mailToAFlag
);

  function automatic logic [`RMC_PTR_W-1:0] fill(
    input logic [`RMC_PTR_W-1:0] wr,
    input logic [`RMC_PTR_W-1:0] rd
  );
    fill = wr - rd;
  endfunction

  function automatic logic [`RMC_PTR_W-1:0] bump(
    input logic [`RMC_PTR_W-1:0] p
  );
    bump = p + `RMC_PTR_W'(1);
  endfunction

  rmc_pkg::rmc_mode_t mode;
  rmc_pkg::rmc_mode_t next_mode;
  logic [`RMC_PTR_W-1:0] wrPtr;
  logic [`RMC_PTR_W-1:0] rdPtr;
  logic [`RMC_PTR_W-1:0] shadowPtr;
  logic [`RMC_PTR_W-1:0] next_wrPtr;
  logic [`RMC_PTR_W-1:0] next_rdPtr;
  logic [`RMC_PTR_W-1:0] next_shadowPtr;
  logic [`RMC_PTR_W-1:0] fillA;
  logic [`RMC_PTR_W-1:0] fillB;
  logic [`RMC_DATA_W-1:0] outWord;
  logic [`RMC_DATA_W-1:0] memWord;
  logic [`RMC_ADDR_W-1:0] memRdAddr;
  logic [`RMC_DATA_W-1:0] mailAB;
  logic [`RMC_DATA_W-1:0] mailBA;
  logic [1:0] readsPast;
  logic exitHold;
  logic portASel;
  logic portBSel;
  logic queueWrite;
  logic queueRead;
  logic entering;
  logic leaving;
  logic replay;
  logic shift;
  logic next_inputReady;
  logic next_notAlmostFull;
  logic portABlock;

  // Port selects; queue accesses use mailbox select low
  assign portASel = !portAChipSelect_n && portAEnable;
  assign portBSel = !portBChipSelect_n && portBEnable;
  assign queueWrite = portASel && portADirection && !portAMailboxSelect
    && portAInputReady; // R22
  // Reads with no new word are ignored
  assign queueRead = portBSel && portBDirection && !portBMailboxSelect
    && portBOutputReady; // R23

  // Mode changes depend on retransmit pins, and entry also on output ready
  assign entering = (mode == rmc_pkg::RMC_NORMAL)
    && retransmitModeRequest && portBOutputReady; // R1 R13
  assign leaving = (mode == rmc_pkg::RMC_RETRANSMIT)
    && !retransmitModeRequest; // R2 R13
  // Exit has priority; replay needs two reads past the mark
  assign replay = (mode == rmc_pkg::RMC_RETRANSMIT)
    && retransmitModeRequest && readFromMark
    && (readsPast == `RMC_MARK_MIN_READS); // R4 R5
  assign shift = !replay && (!portBOutputReady || queueRead)
    && (wrPtr != rdPtr);
  assign memRdAddr = replay ? shadowPtr[`RMC_ADDR_W-1:0]
    : rdPtr[`RMC_ADDR_W-1:0];

  rmc_queue_mem u_mem (
    .mclk(mclk),
    .wrEn(queueWrite),
    .wrAddr(wrPtr[`RMC_ADDR_W-1:0]),
    .wrData(portABusIn),
    .rdAddr(memRdAddr),
    .rdData(memWord)
  );

  always_comb begin
    next_mode = mode;
    case (mode)
      rmc_pkg::RMC_NORMAL: begin
        if (entering) begin
          next_mode = rmc_pkg::RMC_RETRANSMIT; // R1
        end
      end
      rmc_pkg::RMC_RETRANSMIT: begin
        if (leaving) begin
          next_mode = rmc_pkg::RMC_NORMAL; // R2
        end
      end
      default: begin
        next_mode = rmc_pkg::RMC_NORMAL;
      end
    endcase
  end

  always_comb begin
    next_wrPtr = queueWrite ? bump(wrPtr) : wrPtr; // R8
    next_rdPtr = rdPtr;
    if (replay) begin
      next_rdPtr = bump(shadowPtr); // R9
    end else if (shift) begin
      next_rdPtr = bump(rdPtr); // R6
    end
    // Marked word sits one behind the current pointer
    next_shadowPtr = entering ? (rdPtr - `RMC_PTR_W'(1))
      : shadowPtr; // R7
  end

  // Port A flags follow shadow pointer while retransmitting
  assign fillA = fill(next_wrPtr,
    (next_mode == rmc_pkg::RMC_RETRANSMIT) ? next_shadowPtr
    : next_rdPtr); // R7 R11
  assign fillB = fill(next_wrPtr, next_rdPtr); // R6
  assign next_inputReady = fillA < `RMC_DEPTH; // R8
  assign next_notAlmostFull = fillA < (`RMC_DEPTH
    - `RMC_PTR_W'(fifo1FullOffset)); // R8
  assign portABlock = leaving || (exitHold != 1'b0);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode <= rmc_pkg::RMC_NORMAL;
    end else begin
      mode <= next_mode;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      shadowPtr <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      shadowPtr <= next_shadowPtr;
    end
  end

  // Output register and its ready flag
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      outWord <= `RMC_WORD_RESET;
      portBOutputReady <= 1'b0;
    end else if (replay || shift) begin
      outWord <= memWord; // R4
      portBOutputReady <= 1'b1; // R9
    end else if (queueRead) begin
      portBOutputReady <= 1'b0; // R23
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      readsPast <= 2'h0;
    end else if (entering || replay) begin
      readsPast <= 2'h0;
    end else if (queueRead && (readsPast != `RMC_MARK_MIN_READS)) begin
      readsPast <= readsPast + 2'h1; // R4
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      portBAlmostEmpty <= 1'b0;
    end else begin
      portBAlmostEmpty <= fillB > `RMC_PTR_W'(fifo1EmptyOffset); // R10
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      exitHold <= 1'b0;
    end else if (leaving) begin
      exitHold <= `RMC_EXIT_HOLD; // R12
    end else begin
      exitHold <= 1'b0;
    end
  end

  // After exit a rise is held off two edges; falls pass at once
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      portAInputReady <= 1'b1;
      portAAlmostFull <= 1'b1;
    end else if (portABlock) begin
      portAInputReady <= portAInputReady && next_inputReady; // R12
      portAAlmostFull <= portAAlmostFull && next_notAlmostFull; // R12
    end else begin
      portAInputReady <= next_inputReady;
      portAAlmostFull <= next_notAlmostFull;
    end
  end

  rmc_mailbox u_mail_ab (
    .mclk(mclk),
    .arst_n(arst_n),
    .wrReq(portASel && portADirection && portAMailboxSelect), // R15
    .rdReq(portBSel && portBDirection && portBMailboxSelect), // R19
    .wrData(portABusIn),
    .mailWord(mailAB),
    .mailFlag(mailToBFlag)
  );

  rmc_mailbox u_mail_ba (
    .mclk(mclk),
    .arst_n(arst_n),
    .wrReq(portBSel && !portBDirection && portBMailboxSelect), // R16
    .rdReq(portASel && !portADirection && portAMailboxSelect), // R20
    .wrData(portBBusIn),
    .mailWord(mailBA),
    .mailFlag(mailToAFlag)
  );

  // Bus drive: queue register or mailbox by select
  assign portABusOe = !portAChipSelect_n && !portADirection;
  assign portABusOut = portAMailboxSelect ? mailBA : baQueueWord; // R18
  assign portBBusOe = !portBChipSelect_n && portBDirection;
  assign portBBusOut = portBMailboxSelect ? mailAB : outWord; // R14 R18
  assign retransmitActive = (mode == rmc_pkg::RMC_RETRANSMIT);

endmodule

/* pkg/rmc_consts.svh */
// Purpose: Constants for the retransmit queue and mailbox block
// Assumes: Included by bare name; one guard per compile
// Notes: Widths, depth, reset values and cycle counts
`ifndef RMC_CONSTS_SVH
`define RMC_CONSTS_SVH

`define RMC_DATA_W 32
`define RMC_ADDR_W 9
`define RMC_PTR_W 10
`define RMC_DEPTH 10'h200
`define RMC_OFS_W 9
`define RMC_MARK_MIN_READS 2'h2
`define RMC_EXIT_HOLD 1'h1
`define RMC_MAIL_RESET 32'h0000_0000
`define RMC_WORD_RESET 32'h0000_0000

`endif

/* pkg/rmc_pkg.sv */
// Purpose: Types shared by the retransmit queue and mailbox block
// Assumes: Nothing is imported; users write rmc_pkg::name
// Notes: Mode of the A-to-B queue read side
package rmc_pkg;

  typedef enum logic {
    RMC_NORMAL,
    RMC_RETRANSMIT
  } rmc_mode_t;

endpackage

/* testbench/rmc_far_port.sv */
// Purpose: Far-side stand-in for the B-to-A queue output word
// Assumes: One word popped per port A queue read
// Notes: Word moves on each pop so stale data shows
module rmc_far_port (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic popReq,
  output logic [31:0] word
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      word <= 32'h5A5A_0001;
    end else if (popReq) begin
      word <= {word[30:0], word[31] ^ word[21]};
    end
  end
endmodule

/* testbench/rmc_retransmit_mailbox_monitor.sv */
// Purpose: Port checks for retransmit mode and mailboxes
// Assumes: Bound to rmc_retransmit_mailbox; one clock
// Notes: Sees top-level ports only
module rmc_retransmit_mailbox_monitor (
  input wire logic portABusOe,
  input wire logic portBBusOe,
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic portAChipSelect_n,
  input wire logic portADirection,
  input wire logic portAEnable,
  input wire logic portAMailboxSelect,
  input wire logic [31:0] portABusOut,
  input wire logic [31:0] baQueueWord,
  input wire logic portBChipSelect_n,
  input wire logic portBDirection,
  input wire logic portBEnable,
  input wire logic portBMailboxSelect,
  input wire logic [31:0] portBBusOut,
  input wire logic retransmitModeRequest,
  input wire logic readFromMark,
  input wire logic portAInputReady,
  input wire logic portBOutputReady,
  input wire logic retransmitActive,
  input wire logic mailToBFlag,
  input wire logic mailToAFlag
);
  timeunit 1ns;
  timeprecision 1ps;
  wire selA = !portAChipSelect_n && portAEnable;
  wire selB = !portBChipSelect_n && portBEnable;
  wire mwA = selA && portADirection && portAMailboxSelect;
  wire mrA = selA && !portADirection && portAMailboxSelect;
  wire mwB = selB && !portBDirection && portBMailboxSelect;
  wire mrB = selB && portBDirection && portBMailboxSelect;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  AST_ENTER: assert property (
    !retransmitActive && retransmitModeRequest && portBOutputReady
    |=> retransmitActive) else $error("entry missed");
  AST_EXIT: assert property (
    retransmitActive && !retransmitModeRequest |=> !retransmitActive)
    else $error("exit missed");
  AST_EXIT_HOLD: assert property (
    retransmitActive && !retransmitModeRequest && !portAInputReady
    |=> !portAInputReady [*2]) else $error("early ready rise");
  AST_MAIL_B_SET: assert property (
    mwA && mailToBFlag |=> !mailToBFlag) else $error("mail B set");
  AST_MAIL_B_KEEP: assert property (
    !mailToBFlag && !mrB |=> !mailToBFlag) else $error("mail B kept");
  AST_MAIL_B_CLR: assert property (
    mrB && !mwA |=> mailToBFlag) else $error("mail B read");
  AST_MAIL_A_SET: assert property (
    mwB && mailToAFlag |=> !mailToAFlag) else $error("mail A set");
  AST_MAIL_A_CLR: assert property (
    mrA && !mwB |=> mailToAFlag) else $error("mail A read");
  AST_MUX_A: assert property (
    !portAMailboxSelect |-> portABusOut == baQueueWord)
    else $error("port A mux");
  AST_OE_A: assert property (
    portABusOe == (!portAChipSelect_n && !portADirection))
    else $error("port A drive");
  AST_OE_B: assert property (
    portBBusOe == (!portBChipSelect_n && portBDirection))
    else $error("port B drive");
  AST_MAIL_HOLD: assert property (
    portBMailboxSelect && $past(portBMailboxSelect) && !$past(mwA)
    |-> $stable(portBBusOut)) else $error("mailbox changed");
  cover property (retransmitActive && readFromMark);
  cover property ($fell(retransmitActive));
  cover property ($fell(portAInputReady));
endmodule

/* testbench/rmc_retransmit_mailbox_tb_top.sv */
// Purpose: Self-checking bench for retransmit queue and mailboxes
// Assumes: One 20 ns clock serves both ports
// Notes: Notes queue feeds a separate compare process
module rmc_retransmit_mailbox_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0] sel;
    logic [31:0] val;
  } rmc_note_t;
  logic mclk, arst_n, portAChipSelect_n, portADirection, portAEnable;
  logic portAMailboxSelect, portABusOe, portBChipSelect_n, portBDirection;
  logic portBEnable, portBMailboxSelect, portBBusOe, retransmitModeRequest;
  logic readFromMark, portAInputReady, portAAlmostFull, portBOutputReady;
  logic portBAlmostEmpty, retransmitActive, mailToBFlag, mailToAFlag;
  logic [31:0] portABusIn, portABusOut, baQueueWord, portBBusIn;
  logic [31:0] portBBusOut, d, tally, na;
  logic [31:0] w [4];
  logic [31:0] seen [4];
  logic [8:0] fifo1FullOffset = 9'h008;
  logic [8:0] fifo1EmptyOffset = 9'h002;
  logic [3:0] ctlA, ctlB;
  logic [31:0] seed = 32'h9D1F_DE13;
  rmc_note_t notes [$];
  event look;
  int miscompares = 0;
  int tests_run = 0;
  // Control nibble: select_n, direction, enable, mailbox select
  assign {portAChipSelect_n, portADirection, portAEnable,
    portAMailboxSelect} = ctlA;
  assign {portBChipSelect_n, portBDirection, portBEnable,
    portBMailboxSelect} = ctlB;
  assign seen[0] = portBBusOut;
  assign seen[1] = portABusOut;
  assign seen[2] = {25'h0, portAInputReady, portAAlmostFull,
    portBOutputReady, portBAlmostEmpty, retransmitActive, mailToBFlag,
    mailToAFlag};
  assign seen[3] = tally;
  rmc_retransmit_mailbox dut (.*);
  rmc_far_port far (.mclk(mclk), .arst_n(arst_n),
    .popReq(ctlA == 4'h2), .word(baQueueWord));
  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [1:0] s, input logic [31:0] v);
    #2;
    notes.push_back({s, v});
    -> look;
    #1;
  endtask
  // One transfer: set after an edge, taken at the next, then released
  task automatic go(input logic [3:0] ca, input logic [3:0] cb,
    input logic [31:0] dv, input logic f);
    @(posedge mclk);
    ctlA <= ca;
    ctlB <= cb;
    portABusIn <= dv;
    portBBusIn <= dv;
    readFromMark <= f;
    @(posedge mclk);
    ctlA <= {1'h1, ca[2], 1'h0, ca[0]};
    ctlB <= {1'h1, cb[2], 1'h0, cb[0]};
    readFromMark <= 1'h0;
  endtask
  task automatic waitf(input int b, input logic v);
    for (int i = 0; i < 16 && seen[2][b] !== v; i++) @(posedge mclk);
  endtask
  task automatic final_report();
    if (miscompares == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial forever begin
    rmc_note_t n;
    @(look);
    n = notes.pop_front();
    tests_run++;
    if (seen[n.sel] !== n.val) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, seen[n.sel],
        n.val);
    end
  end
  initial begin
    #200000;
    miscompares++;
    final_report();
  end
  initial begin
    arst_n = 1'h0;
    ctlA = 4'h8;
    ctlB = 4'h8;
    readFromMark = 1'h0;
    retransmitModeRequest = 1'h0;
    portABusIn = 32'h0;
    portBBusIn = 32'h0;
    tally = 32'h0;
    na = 32'h0;
    repeat (12) @(posedge mclk);
    arst_n <= 1'h1;
    chk(2, 32'h63);
    go(4'h8, 4'h6, 32'h0, 1'h0);
    chk(0, 32'h0);
    d = rnd();
    go(4'h7, 4'h8, d, 1'h0);
    chk(2, 32'h61);
    go(4'h7, 4'h8, ~d, 1'h0);
    go(4'h8, 4'h7, 32'h0, 1'h0);
    chk(0, d);
    chk(2, 32'h63);
    go(4'h8, 4'h7, 32'h0, 1'h0);
    chk(0, d);
    d = rnd();
    go(4'h8, 4'h3, d, 1'h0);
    chk(2, 32'h62);
    go(4'h8, 4'h3, ~d, 1'h0);
    go(4'h3, 4'h8, 32'h0, 1'h0);
    chk(1, d);
    chk(2, 32'h63);
    go(4'h2, 4'h8, 32'h0, 1'h0);
    for (int i = 0; i < 4; i++) begin
      w[i] = rnd();
      go(4'h6, 4'h8, w[i], 1'h0);
    end
    waitf(3, 1'h1);
    chk(0, w[0]);
    chk(2, 32'h7B);
    @(posedge mclk);
    retransmitModeRequest <= 1'h1;
    go(4'h8, 4'h6, 32'h0, 1'h0);
    chk(0, w[1]);
    go(4'h8, 4'h8, 32'h0, 1'h1);
    chk(0, w[1]);
    go(4'h8, 4'h6, 32'h0, 1'h0);
    waitf(3, 1'h0);
    chk(2, 32'h77);
    go(4'h8, 4'h8, 32'h0, 1'h1);
    chk(0, w[0]);
    repeat (2) @(posedge mclk);
    chk(2, 32'h7F);
    go(4'h8, 4'h6, 32'h0, 1'h0);
    chk(0, w[1]);
    while (portAInputReady === 1'h1 && tally < 32'h258) begin
      go(4'h6, 4'h8, rnd(), 1'h0);
      tally++;
      #2;
      if (portAAlmostFull === 1'h0 && na == 32'h0) begin
        na = tally;
      end
    end
    chk(3, 32'h1FC);
    tally = na;
    chk(3, 32'h1F4);
    @(posedge mclk);
    retransmitModeRequest <= 1'h0;
    waitf(6, 1'h1);
    chk(2, 32'h5B);
    final_report();
  end
endmodule

bind rmc_retransmit_mailbox rmc_retransmit_mailbox_monitor mon (.*);
